// >>> design/ttd_top.sv
`timescale 1ns/1ns
// Operation
// RL1: Bit 62 chooses flat table or two-level table of descriptor pages.
// RL2: Level-one descriptors are 64-bit words fetched in little-endian byte order.
// RL3: Flat-only build makes bit 62 read zero and drop writes.
// RL4: Bits 61:59 give inner cacheability, device memory up to write-back.
// RL5: Bits 58:56 read-only table kind: none, device, processor element, collection.
// RL6: At most one collection slot, one device slot, one processor element slot.
// RL7: Slot 0 device, slot 1 collection or none, slot 2 element or none.
// RL8: Bits 55:53 give outer cacheability; zero follows the inner field. The walker view carries the raw outer field, zero included.
// RL9: Bits 52:48 read-only entry size in bytes minus one.
// RL10: For 4KB or 16KB pages bits 47:12 are base bits 47:12.
// RL11: For 64KB pages bits 15:12 become base bits 51:48.
// RL12: Misaligned base bits may be treated as zero; software must align.
// RL13: Address bits above the implemented width read zero, writes ignored.
// RL14: Bits 11:10 shareability; reserved code behaves as non-shareable.
// RL15: Bits 9:8 page size; reserved code behaves as 64KB.
// RL16: Page size may be fixed and read-only; other attributes stay writable.
// RL17: Bits 7:0 hold allocated page count minus one.
// RL18: Unimplemented slot reads zero page count and ignores writes.
// RL19: Most fields start unknown; software programs them before enabling.
// RL20: Command queue descriptor is 64-bit with independent 32-bit halves.
// RL21: Bit 63 marks allocated memory, resets zero, gates translation writes.
// RL22: Software must not write descriptors while service runs or is busy.
// RL23: Each descriptor half is reachable by itself.
// RL24: Writes leave read-only fields unchanged and update writable ones.
module ttd_top #(
  parameter bit HAS_COLL = 1'b1,
  parameter bit HAS_VPE = 1'b0,
  parameter bit FLAT_ONLY = 1'b0,
  parameter bit COLL_IN_CORE = 1'b0,
  parameter int PA_BITS = 48,
  parameter logic [4:0] DEV_ESIZE = 5'h07,
  parameter logic [4:0] COLL_ESIZE = 5'h07,
  parameter logic [4:0] VPE_ESIZE = 5'h0f,
  parameter int IDX_W = 23
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register frame port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // Decoded tables for the walker
  output ttd_pkg::ttd_walk_t [ttd_pkg::TTD_NUM-1:0] walk_desc,
  // Command queue descriptor
  output logic [63:0] cmdq_desc,
  output logic cmdq_written,
  // Translation page write gate
  input wire logic xlate_wr,
  output logic xlate_wr_pass,
  output logic xlate_wr_drop,
  // Level-one descriptor fetch
  input wire logic l1_req,
  input wire logic [2:0] l1_slot,
  input wire logic [IDX_W-1:0] l1_index,
  output logic l1_addr_valid,
  output logic [51:0] l1_addr,
  input wire logic l1_resp_valid,
  input wire logic [7:0][7:0] l1_resp_bytes,
  output logic l1_desc_valid,
  output logic [63:0] l1_desc
);
  import ttd_pkg::*;

  localparam int CQ_ADDR_TOP = (PA_BITS > TTD_PA_MAX) ? TTD_PA_MAX : PA_BITS;
  localparam logic [63:0] CQ_WMASK = TTD_M_VALID | TTD_M_INNER | TTD_M_OUTER
    | (TTD_M_CQ_ADDR & ((64'h1 << CQ_ADDR_TOP) - 64'h1)) | TTD_M_SHARE | TTD_M_PAGES;

  // Fixed allocation keeps each kind in at most one slot
  function automatic logic [2:0] slot_kind(input int n);
    case (n)
      0: slot_kind = TTD_KIND_DEVICE; // RL7 RL6
      1: slot_kind = HAS_COLL ? TTD_KIND_COLL : TTD_KIND_NONE; // RL7 RL6
      2: slot_kind = HAS_VPE ? TTD_KIND_VPE : TTD_KIND_NONE; // RL7 RL6
      default: slot_kind = TTD_KIND_NONE; // RL7
    endcase
  endfunction

  function automatic logic [4:0] slot_esize(input int n);
    case (n)
      0: slot_esize = DEV_ESIZE;
      1: slot_esize = COLL_ESIZE;
      2: slot_esize = VPE_ESIZE;
      default: slot_esize = 5'h00;
    endcase
  endfunction

  logic rst_q1;
  logic rst_n;

  // Release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Address decode
  wire acc_wr = reg_sel & reg_wr;
  wire hit_slot = (reg_addr >= TTD_OFS_BASE) && (reg_addr < TTD_OFS_END);
  wire hit_cq = (reg_addr[15:3] == TTD_OFS_CMDQ[15:3]);
  wire hi_half = reg_addr[2];
  wire [2:0] slot_idx = reg_addr[5:3];
  // Sub-word addresses are not decoded; any byte in a word picks that word
  wire cq_wr_lo = acc_wr & hit_cq & ~hi_half; // RL20
  wire cq_wr_hi = acc_wr & hit_cq & hi_half; // RL20

  logic [TTD_NUM-1:0][63:0] slot_rd;
  ttd_walk_t [TTD_NUM-1:0] slot_walk;
  logic [TTD_NUM-1:0] slot_blocks;

  genvar g;
  generate
    for (g = 0; g < TTD_NUM; g++) begin : g_slot
      localparam logic [2:0] K = slot_kind(g);
      wire slot_wr = acc_wr & hit_slot & (slot_idx == 3'(g));
      ttd_slot #(
        .KIND(K),
        .ENTRY_SIZE(slot_esize(g)),
        .FLAT_ONLY(FLAT_ONLY),
        .PA_BITS(PA_BITS),
        .FIXED_PAGE(1'b0),
        .PAGE_VAL(TTD_PG_4K)
      ) u_slot (
        .clk(clk),
        .rst_n(rst_n),
        .wr_lo(slot_wr & ~hi_half), // RL23
        .wr_hi(slot_wr & hi_half), // RL23
        .wdata(reg_wdata),
        .rd_value(slot_rd[g]),
        .walk(slot_walk[g])
      );
      // Collections held on chip need no memory, so they never block
      assign slot_blocks[g] = (K != TTD_KIND_NONE) && !(K == TTD_KIND_COLL && COLL_IN_CORE)
        && !slot_walk[g].alloc; // RL21
    end
  endgenerate

  // Command queue descriptor storage
  logic [63:0] cq_q;
  logic [63:0] next_cq;
  assign next_cq[31:0] = cq_wr_lo ? (reg_wdata & CQ_WMASK[31:0]) : cq_q[31:0]; // RL20
  assign next_cq[63:32] = cq_wr_hi ? (reg_wdata & CQ_WMASK[63:32]) : cq_q[63:32]; // RL20

  // Read data select; unmapped words read zero
  wire [63:0] slot_word = slot_rd[slot_idx];
  wire [63:0] sel_word = hit_slot ? slot_word : (hit_cq ? cq_q : 64'h0);
  wire [31:0] next_rdata = (reg_sel & ~reg_wr) ? (hi_half ? sel_word[63:32] : sel_word[31:0]) : 32'h0;

  // Translation page writes are discarded while any needed table lacks memory
  wire gate_closed = |slot_blocks; // RL21

  // Level-one fetch only for two-level tables; flat tables refuse the request
  wire l1_go = l1_req & slot_walk[l1_slot].two_level & (slot_walk[l1_slot].kind != TTD_KIND_NONE); // RL1

  ttd_l1_fetch #(
    .IDX_W(IDX_W)
  ) u_l1 (
    .clk(clk),
    .rst_n(rst_n),
    .req(l1_go),
    .table_base(slot_walk[l1_slot].base),
    .index(l1_index),
    .addr_valid(l1_addr_valid),
    .addr(l1_addr),
    .resp_valid(l1_resp_valid),
    .resp_bytes(l1_resp_bytes),
    .desc_valid(l1_desc_valid),
    .desc(l1_desc)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
      reg_ack <= 1'b0;
      cq_q <= 64'h0; // RL19
      cmdq_written <= 1'b0;
      xlate_wr_pass <= 1'b0;
      xlate_wr_drop <= 1'b0;
      walk_desc <= '0;
    end else begin
      reg_rdata <= next_rdata;
      reg_ack <= reg_sel;
      cq_q <= next_cq;
      cmdq_written <= cq_wr_lo | cq_wr_hi;
      xlate_wr_pass <= xlate_wr & ~gate_closed; // RL21
      xlate_wr_drop <= xlate_wr & gate_closed; // RL21
      walk_desc <= slot_walk;
    end
  end

  assign cmdq_desc = cq_q;
endmodule

// >>> design/ttd_pkg.sv
package ttd_pkg;

  localparam int TTD_NUM = 8;

  // Register frame byte offsets
  localparam logic [15:0] TTD_OFS_CMDQ = 16'h0080;
  localparam logic [15:0] TTD_OFS_BASE = 16'h0100;
  localparam logic [15:0] TTD_OFS_END = 16'h0140;

  // Descriptor field positions
  localparam int TTD_VALID_BIT = 63;
  localparam int TTD_TWO_LEVEL_BIT = 62;
  localparam int TTD_INNER_LSB = 59;
  localparam int TTD_KIND_LSB = 56;
  localparam int TTD_OUTER_LSB = 53;
  localparam int TTD_ESIZE_LSB = 48;
  localparam int TTD_ADDR_LSB = 12;
  localparam int TTD_SHARE_LSB = 10;
  localparam int TTD_PSIZE_LSB = 8;
  localparam int TTD_PAGES_LSB = 0;

  // Writable field masks
  localparam logic [63:0] TTD_M_VALID = 64'h8000_0000_0000_0000;
  localparam logic [63:0] TTD_M_TWO_LEVEL = 64'h4000_0000_0000_0000;
  localparam logic [63:0] TTD_M_INNER = 64'h3800_0000_0000_0000;
  localparam logic [63:0] TTD_M_OUTER = 64'h00e0_0000_0000_0000;
  localparam logic [63:0] TTD_M_ADDR = 64'h0000_ffff_ffff_f000;
  localparam logic [63:0] TTD_M_CQ_ADDR = 64'h000f_ffff_ffff_f000;
  localparam logic [63:0] TTD_M_SHARE = 64'h0000_0000_0000_0c00;
  localparam logic [63:0] TTD_M_PSIZE = 64'h0000_0000_0000_0300;
  localparam logic [63:0] TTD_M_PAGES = 64'h0000_0000_0000_00ff;

  localparam int TTD_PA_MAX = 52;
  localparam int TTD_PA_LOW = 48;

  typedef enum logic [2:0] {
    TTD_KIND_NONE = 3'h0,
    TTD_KIND_DEVICE = 3'h1,
    TTD_KIND_VPE = 3'h2,
    TTD_KIND_COLL = 3'h4
  } ttd_kind_t;

  typedef enum logic [1:0] {
    TTD_PG_4K = 2'h0,
    TTD_PG_16K = 2'h1,
    TTD_PG_64K = 2'h2,
    TTD_PG_RSVD = 2'h3
  } ttd_page_t;

  localparam logic [1:0] TTD_SH_NONE = 2'h0;
  localparam logic [1:0] TTD_SH_RSVD = 2'h3;

  typedef struct packed {
    logic alloc;
    logic two_level;
    logic [2:0] inner;
    logic [2:0] outer;
    logic [2:0] kind;
    logic [4:0] entry_size;
    logic [51:0] base;
    logic [1:0] page_size;
    logic [1:0] share;
    logic [7:0] pages;
  } ttd_walk_t;

endpackage

// >>> design/ttd_slot.sv
`timescale 1ns/1ns
module ttd_slot #(
  parameter logic [2:0] KIND = 3'h0,
  parameter logic [4:0] ENTRY_SIZE = 5'h07,
  parameter bit FLAT_ONLY = 1'b0,
  parameter int PA_BITS = 48,
  parameter bit FIXED_PAGE = 1'b0,
  parameter logic [1:0] PAGE_VAL = 2'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Half-word writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  // Read view and decoded table
  output logic [63:0] rd_value,
  output ttd_pkg::ttd_walk_t walk
);
  import ttd_pkg::*;

  localparam bit IMPL = (KIND != TTD_KIND_NONE);
  localparam int ADDR_TOP = (PA_BITS > TTD_PA_LOW) ? TTD_PA_LOW : PA_BITS;
  localparam logic [63:0] ADDR_M = TTD_M_ADDR & ((64'h1 << ADDR_TOP) - 64'h1);
  // Unimplemented slot keeps nothing, so all of it reads zero
  localparam logic [63:0] WMASK = !IMPL ? 64'h0 : (TTD_M_VALID | (FLAT_ONLY ? 64'h0 : TTD_M_TWO_LEVEL)
    | TTD_M_INNER | TTD_M_OUTER | ADDR_M | TTD_M_SHARE | (FIXED_PAGE ? 64'h0 : TTD_M_PSIZE) | TTD_M_PAGES);
  localparam logic [63:0] RO_VAL = !IMPL ? 64'h0 :
    {5'h00, KIND, 3'h0, ENTRY_SIZE, 38'h0, (FIXED_PAGE ? PAGE_VAL : 2'h0), 8'h00};
  localparam logic [51:0] PA_M = (PA_BITS >= TTD_PA_MAX) ? {52{1'b1}} : ((52'h1 << PA_BITS) - 52'h1);

  logic [63:0] q;
  logic [63:0] next_q;
  logic [1:0] psize_raw;
  logic [1:0] psize_eff;
  logic [1:0] share_raw;
  logic [51:0] base_raw;

  // Read-only fields are never stored, so writes cannot reach them
  assign next_q[31:0] = wr_lo ? ((q[31:0] & ~WMASK[31:0]) | (wdata & WMASK[31:0])) : q[31:0]; // RL23 RL24
  assign next_q[63:32] = wr_hi ? ((q[63:32] & ~WMASK[63:32]) | (wdata & WMASK[63:32])) : q[63:32]; // RL23
  assign rd_value = q | RO_VAL; // RL5 RL9 RL18 RL3 RL16

  assign psize_raw = FIXED_PAGE ? PAGE_VAL : q[TTD_PSIZE_LSB +: 2];
  assign psize_eff = (psize_raw == TTD_PG_RSVD) ? TTD_PG_64K : psize_raw; // RL15
  assign share_raw = q[TTD_SHARE_LSB +: 2];

  // Misaligned low bits are dropped rather than mixed into table addressing
  always_comb begin
    case (psize_eff)
      TTD_PG_4K: base_raw = {4'h0, q[47:12], 12'h000}; // RL10
      TTD_PG_16K: base_raw = {4'h0, q[47:14], 14'h0000}; // RL10 RL12
      default: base_raw = {q[15:12], q[47:16], 16'h0000}; // RL11
    endcase
  end

  assign walk.alloc = q[TTD_VALID_BIT]; // RL21
  assign walk.two_level = q[TTD_TWO_LEVEL_BIT]; // RL1
  assign walk.inner = q[TTD_INNER_LSB +: 3]; // RL4
  assign walk.outer = q[TTD_OUTER_LSB +: 3]; // RL8
  assign walk.kind = RO_VAL[TTD_KIND_LSB +: 3];
  assign walk.entry_size = RO_VAL[TTD_ESIZE_LSB +: 5];
  assign walk.base = base_raw & PA_M; // RL13
  assign walk.page_size = psize_eff;
  assign walk.share = (share_raw == TTD_SH_RSVD) ? TTD_SH_NONE : share_raw; // RL14
  assign walk.pages = q[TTD_PAGES_LSB +: 8]; // RL17

  // Every stored field, the allocation flag included, resets to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 64'h0; // RL19 RL21
    end else begin
      q <= next_q;
    end
  end
endmodule

// >>> design/ttd_l1_fetch.sv
`timescale 1ns/1ns
module ttd_l1_fetch #(
  parameter int IDX_W = 23
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Address request
  input wire logic req,
  input wire logic [51:0] table_base,
  input wire logic [IDX_W-1:0] index,
  output logic addr_valid,
  output logic [51:0] addr,
  // Memory return, byte i from address addr+i
  input wire logic resp_valid,
  input wire logic [7:0][7:0] resp_bytes,
  output logic desc_valid,
  output logic [63:0] desc
);
  logic [51:0] next_addr;
  logic [63:0] next_desc;

  // Level-one entries are 8 bytes each
  assign next_addr = table_base + {{(49 - IDX_W){1'b0}}, index, 3'h0}; // RL2

  // Lowest address is least significant whatever the bus lane order
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_byte
      assign next_desc[8*i +: 8] = resp_bytes[i]; // RL2
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_valid <= 1'b0;
      addr <= 52'h0;
      desc_valid <= 1'b0;
      desc <= 64'h0;
    end else begin
      addr_valid <= req;
      desc_valid <= resp_valid;
      if (req) begin
        addr <= next_addr;
      end
      if (resp_valid) begin
        desc <= next_desc;
      end
    end
  end
endmodule

// >>> sim/ttd_monitor.sv
`timescale 1ns/1ns
module ttd_monitor #(
  parameter int IDX_W = 23
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register frame port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic reg_ack,
  input wire logic cmdq_written,
  // Walker side
  input wire ttd_pkg::ttd_walk_t [ttd_pkg::TTD_NUM-1:0] walk_desc,
  input wire logic xlate_wr,
  input wire logic xlate_wr_pass,
  input wire logic xlate_wr_drop,
  input wire logic l1_req,
  input wire logic [2:0] l1_slot,
  input wire logic l1_addr_valid,
  input wire logic l1_resp_valid,
  input wire logic [7:0][7:0] l1_resp_bytes,
  input wire logic l1_desc_valid,
  input wire logic [63:0] l1_desc
);
  import ttd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ack; reg_sel |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_gate; xlate_wr |=> xlate_wr_pass != xlate_wr_drop; endproperty
  a_gate: assert property (p_gate) else $error("gate gave no single verdict");
  // Verdict and walk view both reflect the registers one cycle back
  property p_drop; xlate_wr |=> xlate_wr_drop == (!walk_desc[0].alloc || !walk_desc[1].alloc); endproperty
  a_drop: assert property (p_drop) else $error("write passed without memory");
  property p_cq; reg_sel && reg_wr && reg_addr[15:3] == 13'h010 |=> cmdq_written; endproperty
  a_cq: assert property (p_cq) else $error("queue write not flagged");
  property p_cq_src; cmdq_written |-> $past(reg_sel && reg_wr && reg_addr[15:3] == 13'h010); endproperty
  a_cq_src: assert property (p_cq_src) else $error("queue flag without write");
  property p_kind;
    $past(resetn, 3) |-> walk_desc[0].kind == 3'h1 && walk_desc[1].kind == 3'h4 && walk_desc[2].kind == 3'h0
      && walk_desc[0].entry_size == 5'h07;
  endproperty
  a_kind: assert property (p_kind) else $error("slot kinds wrong");
  property p_pages; walk_desc[2].pages == 8'h0 && walk_desc[7].pages == 8'h0 && walk_desc[3].base == 52'h0; endproperty
  a_pages: assert property (p_pages) else $error("empty slot not zero");
  property p_eff; walk_desc[0].page_size != 2'h3 && walk_desc[0].share != 2'h3; endproperty
  a_eff: assert property (p_eff) else $error("reserved code leaked");
  property p_l1ref; l1_req && walk_desc[l1_slot].kind == 3'h0 |=> !l1_addr_valid; endproperty
  a_l1ref: assert property (p_l1ref) else $error("fetch from empty slot");
  property p_l1d; l1_resp_valid |=> l1_desc_valid && l1_desc == $past(l1_resp_bytes); endproperty
  a_l1d: assert property (p_l1d) else $error("descriptor byte order wrong");
endmodule

bind ttd_top ttd_monitor #(.IDX_W(IDX_W)) i_ttd_monitor (.clk(clk), .resetn(resetn), .reg_sel(reg_sel),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_ack(reg_ack), .cmdq_written(cmdq_written), .walk_desc(walk_desc),
  .xlate_wr(xlate_wr), .xlate_wr_pass(xlate_wr_pass), .xlate_wr_drop(xlate_wr_drop), .l1_req(l1_req),
  .l1_slot(l1_slot), .l1_addr_valid(l1_addr_valid), .l1_resp_valid(l1_resp_valid),
  .l1_resp_bytes(l1_resp_bytes), .l1_desc_valid(l1_desc_valid), .l1_desc(l1_desc));

// >>> sim/ttd_top_tb.sv
`timescale 1ns/1ns
module ttd_top_tb;
  import ttd_pkg::*;
  logic clk, resetn, reg_sel, reg_wr, reg_ack, cmdq_written, xlate_wr, xlate_wr_pass, xlate_wr_drop;
  logic l1_req, l1_addr_valid, l1_resp_valid, l1_desc_valid;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, d;
  ttd_walk_t [TTD_NUM-1:0] walk_desc;
  logic [63:0] cmdq_desc, l1_desc;
  logic [2:0] l1_slot;
  logic [22:0] l1_index;
  logic [51:0] l1_addr;
  logic [7:0][7:0] l1_resp_bytes;
  logic [63:0] mdl [9];
  int miscompares, num_checks;

  ttd_top i_ttd_top (.clk(clk), .resetn(resetn), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .walk_desc(walk_desc),
    .cmdq_desc(cmdq_desc), .cmdq_written(cmdq_written), .xlate_wr(xlate_wr), .xlate_wr_pass(xlate_wr_pass),
    .xlate_wr_drop(xlate_wr_drop), .l1_req(l1_req), .l1_slot(l1_slot), .l1_index(l1_index),
    .l1_addr_valid(l1_addr_valid), .l1_addr(l1_addr), .l1_resp_valid(l1_resp_valid),
    .l1_resp_bytes(l1_resp_bytes), .l1_desc_valid(l1_desc_valid), .l1_desc(l1_desc));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Writable bits; slots 2..7 are absent in this build
  function automatic logic [31:0] wmask(int i, bit h);
    if (i == 8) return h ? 32'hb8e0_ffff : 32'hffff_fcff;
    return (i < 2) ? (h ? 32'hf8e0_ffff : 32'hffff_ffff) : 32'h0;
  endfunction

  function automatic logic [31:0] ro(int i, bit h);
    return (h && i < 2) ? {5'h0, (i == 1) ? 3'h4 : 3'h1, 8'h07, 16'h0} : 32'h0;
  endfunction

  function automatic logic [15:0] adr(int i, bit h);
    return (i == 8) ? 16'(16'h80 + 4 * h) : 16'(16'h100 + 8 * i + 4 * h);
  endfunction

  function automatic ttd_walk_t wexp(int i);
    ttd_walk_t e;
    logic [63:0] m;
    m = mdl[i] | {ro(i, 1), 32'h0};
    e.alloc = m[63];
    e.two_level = m[62];
    e.inner = m[61:59];
    e.kind = m[58:56];
    e.outer = m[55:53];
    e.entry_size = m[52:48];
    e.page_size = (m[9:8] == 2'h3) ? 2'h2 : m[9:8];
    e.share = (m[11:10] == 2'h3) ? 2'h0 : m[11:10];
    e.pages = m[7:0];
    e.base = {4'h0, m[47:12], 12'h0};
    // Misaligned low base bits are dropped; 64KB high bits lie above the 48-bit space
    if (e.page_size == 2'h1) e.base[13:12] = 2'h0;
    if (e.page_size == 2'h2) e.base[15:12] = 4'h0;
    return e;
  endfunction

  task automatic acc(input bit w, input logic [15:0] a, input logic [31:0] wd);
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = wd;
    @(posedge clk);
    #1;
    reg_sel = 1'b0;
    chk(reg_ack, 1);
    chk(cmdq_written, w && a[15:3] == 13'h010);
    rd = reg_rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(int i, bit h, logic [31:0] wd);
    acc(1, adr(i, h), wd);
    if (h) mdl[i][63:32] = wd & wmask(i, 1);
    else mdl[i][31:0] = wd & wmask(i, 0);
  endtask

  task automatic rdchk(int i, bit h);
    acc(0, adr(i, h), 32'h0);
    chk(rd, (h ? mdl[i][63:32] : mdl[i][31:0]) | ro(i, h));
  endtask

  task automatic xl(bit pass);
    xlate_wr = 1'b1;
    @(posedge clk);
    #1;
    xlate_wr = 1'b0;
    chk({xlate_wr_pass, xlate_wr_drop}, {pass, !pass});
    @(posedge clk);
    #1;
  endtask

  task automatic l1(logic [2:0] s, bit ok);
    l1_req = 1'b1;
    l1_slot = s;
    l1_index = 23'($urandom);
    @(posedge clk);
    #1;
    l1_req = 1'b0;
    chk(l1_addr_valid, ok);
    if (ok) chk(l1_addr, wexp(s).base + {26'h0, l1_index, 3'h0});
    l1_resp_valid = 1'b1;
    l1_resp_bytes = {$urandom, $urandom};
    @(posedge clk);
    #1;
    l1_resp_valid = 1'b0;
    chk({l1_desc_valid, l1_desc}, {1'b1, l1_resp_bytes});
    @(posedge clk);
    #1;
  endtask

  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(90029));
    {resetn, reg_sel, reg_wr, xlate_wr, l1_req, l1_resp_valid} = '0;
    {reg_addr, reg_wdata, l1_slot, l1_index, l1_resp_bytes} = '0;
    for (int i = 0; i < 9; i++) mdl[i] = 64'h0;
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // Reset contents, fixed kinds and entry sizes
    for (int i = 0; i < 9; i++) for (int h = 0; h < 2; h++) rdchk(i, h);
    // Random traffic on every half, independent halves
    repeat (4) begin
      for (int i = 0; i < 9; i++) for (int h = 0; h < 2; h++) begin
        wr(i, h, $urandom);
        rdchk(i, h);
      end
      for (int i = 0; i < 8; i++) chk(walk_desc[i], wexp(i));
      chk(cmdq_desc, mdl[8]);
    end
    // Unmapped places read zero and keep nothing
    for (int k = 0; k < 4; k++) begin
      acc(1, (k == 0) ? 16'h0 : (k == 1) ? 16'h88 : (k == 2) ? 16'h140 : 16'hfffc, $urandom);
      chk(rd, 32'h0);
      acc(0, (k == 0) ? 16'h0 : (k == 1) ? 16'h88 : (k == 2) ? 16'h140 : 16'hfffc, 32'h0);
      chk(rd, 32'h0);
    end
    // Every page size and shareability code, reserved ones included
    for (int k = 0; k < 16; k++) begin
      d = $urandom;
      d[11:8] = 4'(k);
      wr(0, 0, d);
      chk(walk_desc[0], wexp(0));
    end
    // Gate follows allocation of both implemented tables
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      d[31:30] = {k[0], 1'b1};
      wr(0, 1, d);
      wr(1, 1, {k[1], 31'h0});
      xl(k == 3);
    end
    l1(3'h0, 1'b1);
    l1(3'h0, 1'b1);
    l1(3'h1, 1'b0);
    l1(3'h5, 1'b0);
    tally_and_finish();
  end
endmodule
